// ---- rtl/fps_sequencer.sv ----
/*
 Flash program/erase command sequencer with status flags and
 sector write protection. Assumes the array model outside does
 the cell work: it takes program/erase requests and reports fail.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.svh"
module fps_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Processor bus cycle
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [11:0] busAddr,
  input wire logic [7:0] wrData,
  input wire logic [11:0] sectorSelects,
  input wire logic [7:0] arrayData,
  output logic [7:0] rdData,
  // Protection register, read-only from the core
  input wire logic [11:0] sectorProtect,
  output logic [7:0] sectorWriteProtectStatus,
  // Array operation requests
  output logic progReq,
  output logic [7:0] progData,
  output logic [11:0] eraseSectors,
  output logic eraseReq,
  output logic bulkReq,
  output logic bulkFill,
  output logic [11:0] invalidSectors,
  input wire logic opFail,
  // Completion
  output logic readyBusyOutput
);
  fps_pkg::fps_op_e op_q;
  logic [2:0] stage;
  logic bypass_q;
  logic bypProg_q;
  logic bypExit_q;
  logic toggle_q;
  logic errFlag_q;
  logic tmoFlag_q;
  logic [7:0] polData_q;
  logic [1:0] tries_q;
  logic tLoad;
  logic [14:0] tCount;
  logic tDone;
  logic opLoad;
  logic opDone;
  logic selAny;
  logic unlocked;
  logic prefClear;
  logic selProt;
  assign selAny = |sectorSelects;
  assign unlocked = stage == 3'd2;
  assign selProt = |(sectorSelects & sectorProtect);

  fps_cmd_decode uDec (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrStb(wrStb && op_q == fps_pkg::FPS_IDLE && !bypass_q),
    .wrAddr(busAddr),
    .wrData(wrData),
    .clear(prefClear),
    .stage(stage)
  );
  // Window timer: erase time-out, suspend latency, protect toggle
  fps_timer uWin (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(tLoad),
    .count(tCount),
    .run(1'b1),
    .done(tDone)
  );
  // Internal operation length timer
  fps_timer uOp (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(opLoad),
    .count(15'(`FPS_OP_CYC)),
    .run(1'b1),
    .done(opDone)
  );

  wire isSusp = wrStb && selAny && wrData == `FPS_CMD_SUSP;
  wire isRes = wrStb && selAny && wrData == `FPS_CMD_SERA;
  wire isRst = wrStb && wrData == `FPS_CMD_RST;
  wire eraseCmd = wrStb && stage == 3'd5 && wrData == `FPS_CMD_SERA;
  wire bulkCmd = wrStb && stage == 3'd5 && wrData == `FPS_CMD_BULK &&
    busAddr == `FPS_ADR_555;
  wire progCmd = wrStb && unlocked && wrData == `FPS_CMD_PROG &&
    busAddr == `FPS_ADR_555;
  wire bypCmd = wrStb && unlocked && wrData == `FPS_CMD_BYP &&
    busAddr == `FPS_ADR_555;
  wire bypData = wrStb && bypass_q && bypProg_q;
  logic progArm_q;
  wire progWrite = (wrStb && progArm_q && op_q == fps_pkg::FPS_IDLE) ||
    bypData;

  // Prefix decoder restarts on a decoded erase, bulk, program, bypass or reset command
  assign prefClear = eraseCmd || bulkCmd || progCmd || bypCmd || isRst;

  // Standard program: A0h arms the next write as data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      progArm_q <= 1'b0;
    end else if (wrStb) begin
      progArm_q <= progCmd;
    end
  end

  // Unlock-bypass mode entry, program and exit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bypass_q <= 1'b0;
      bypProg_q <= 1'b0;
      bypExit_q <= 1'b0;
    end else if (wrStb && op_q == fps_pkg::FPS_IDLE) begin
      if (!bypass_q) begin
        bypass_q <= bypCmd;
      end else if (bypProg_q) begin
        bypProg_q <= 1'b0;
      end else if (bypExit_q) begin
        bypExit_q <= 1'b0;
        if (wrData == `FPS_CMD_BYPX2) begin
          bypass_q <= 1'b0;
        end
      end else begin
        // Anything else is invalid and dropped
        bypProg_q <= wrData == `FPS_CMD_PROG;
        bypExit_q <= wrData == `FPS_CMD_BYPX;
      end
    end
  end

  // Operation state machine
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      op_q <= fps_pkg::FPS_IDLE;
      eraseSectors <= 12'h000;
      invalidSectors <= 12'h000;
      tries_q <= 2'd0;
    end else begin
      case (op_q)
        fps_pkg::FPS_IDLE: begin
          if (progWrite && !selProt && selAny) begin
            op_q <= fps_pkg::FPS_PROG;
          end else if (eraseCmd) begin
            eraseSectors <= sectorSelects & ~sectorProtect;
            op_q <= fps_pkg::FPS_TMO;
          end else if (bulkCmd) begin
            tries_q <= 2'd0;
            eraseSectors <= ~sectorProtect;
            op_q <= fps_pkg::FPS_BULK;
          end
        end
        fps_pkg::FPS_PROG: begin
          if (opDone) begin
            op_q <= opFail ? fps_pkg::FPS_ERR : fps_pkg::FPS_IDLE;
          end
        end
        fps_pkg::FPS_TMO: begin
          if (wrStb && wrData == `FPS_CMD_SERA) begin
            eraseSectors <= eraseSectors |
              (sectorSelects & ~sectorProtect);
          end else if (isSusp) begin
            op_q <= fps_pkg::FPS_SUSP;
          end else if (wrStb) begin
            eraseSectors <= 12'h000;
            op_q <= fps_pkg::FPS_IDLE;
          end else if (tDone) begin
            op_q <= eraseSectors == 12'h000 ? fps_pkg::FPS_PROT
                                             : fps_pkg::FPS_ERASE;
          end
        end
        fps_pkg::FPS_ERASE: begin
          if (isRst) begin
            invalidSectors <= invalidSectors | eraseSectors;
            op_q <= fps_pkg::FPS_IDLE;
          end else if (isSusp) begin
            op_q <= fps_pkg::FPS_SUSP;
          end else if (opDone) begin
            invalidSectors <= invalidSectors & ~eraseSectors;
            op_q <= opFail ? fps_pkg::FPS_ERR : fps_pkg::FPS_IDLE;
          end
        end
        fps_pkg::FPS_SUSP: begin
          if (isRes) begin
            op_q <= fps_pkg::FPS_ERASE;
          end else if (isRst) begin
            invalidSectors <= invalidSectors | eraseSectors;
            op_q <= fps_pkg::FPS_IDLE;
          end
        end
        fps_pkg::FPS_BULK: begin
          // Fill with 00h, then erase; retry on fail
          if (opDone) begin
            if (!opFail) begin
              op_q <= fps_pkg::FPS_IDLE;
            end else if (tries_q == 2'(`FPS_ERASE_TRIES - 1)) begin
              op_q <= fps_pkg::FPS_ERR;
            end else begin
              tries_q <= tries_q + 2'd1;
            end
          end
        end
        fps_pkg::FPS_ERR: begin
          if (isRst) begin
            op_q <= fps_pkg::FPS_IDLE;
          end
        end
        fps_pkg::FPS_PROT: begin
          if (tDone) begin
            op_q <= fps_pkg::FPS_IDLE;
          end
        end
        default: op_q <= fps_pkg::FPS_IDLE;
      endcase
    end
  end

  // Timer loads from cycle counts
  always_comb begin
    tLoad = 1'b0;
    tCount = 15'(`FPS_TMO_CYC);
    if ((op_q == fps_pkg::FPS_IDLE && eraseCmd) ||
        (op_q == fps_pkg::FPS_TMO && wrStb && wrData == `FPS_CMD_SERA)) begin
      tLoad = 1'b1;
    end else if (op_q == fps_pkg::FPS_TMO && tDone) begin
      tLoad = 1'b1;
      tCount = 15'(`FPS_PROT_CYC);
    end else if (isSusp && (op_q == fps_pkg::FPS_ERASE ||
                           op_q == fps_pkg::FPS_TMO)) begin
      tLoad = 1'b1;
      tCount = 15'(`FPS_SUSP_CYC);
    end
  end
  assign opLoad = (op_q == fps_pkg::FPS_IDLE && (progWrite || bulkCmd)) ||
    (op_q == fps_pkg::FPS_TMO && tDone) ||
    (op_q == fps_pkg::FPS_SUSP && isRes) ||
    (op_q == fps_pkg::FPS_BULK && opDone);

  // Suspend latency: toggling continues until timer expiry
  logic suspSettle_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      suspSettle_q <= 1'b0;
    end else if (op_q != fps_pkg::FPS_SUSP) begin
      suspSettle_q <= isSusp;
    end else if (tDone) begin
      suspSettle_q <= 1'b0;
    end
  end
  wire busy = op_q == fps_pkg::FPS_PROG || op_q == fps_pkg::FPS_TMO ||
    op_q == fps_pkg::FPS_ERASE || op_q == fps_pkg::FPS_BULK ||
    op_q == fps_pkg::FPS_PROT || suspSettle_q;

  // Toggle inverts on each read while busy
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      toggle_q <= 1'b0;
    end else if (rdStb && selAny && busy) begin
      toggle_q <= ~toggle_q;
    end
  end
  // Error flag sticky until reset-flash
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      errFlag_q <= 1'b0;
    end else if (opDone && opFail && op_q != fps_pkg::FPS_BULK) begin
      errFlag_q <= 1'b1;
    end else if (op_q == fps_pkg::FPS_BULK && opDone && opFail &&
                 tries_q == 2'(`FPS_ERASE_TRIES - 1)) begin
      errFlag_q <= 1'b1;
    end else if (isRst && op_q == fps_pkg::FPS_ERR) begin
      errFlag_q <= 1'b0;
    end
  end
  // Time-out flag 0 in window, 1 after
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tmoFlag_q <= 1'b1;
    end else if (op_q == fps_pkg::FPS_IDLE && eraseCmd) begin
      tmoFlag_q <= 1'b0;
    end else if (op_q == fps_pkg::FPS_TMO && (tDone || isSusp)) begin
      tmoFlag_q <= 1'b1;
    end
  end
  // Data captured for polling
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      polData_q <= `FPS_ERASED;
    end else if (op_q == fps_pkg::FPS_IDLE && progWrite) begin
      polData_q <= wrData;
    end else if (op_q == fps_pkg::FPS_IDLE && (eraseCmd || bulkCmd)) begin
      polData_q <= `FPS_ERASED;
    end
  end
  // Array request outputs, registered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      progReq <= 1'b0;
      progData <= `FPS_ERASED;
      eraseReq <= 1'b0;
      bulkReq <= 1'b0;
      bulkFill <= 1'b0;
    end else begin
      progReq <= op_q == fps_pkg::FPS_IDLE && progWrite && !selProt && selAny;
      progData <= arrayData & wrData;
      eraseReq <= op_q == fps_pkg::FPS_ERASE;
      bulkReq <= op_q == fps_pkg::FPS_BULK;
      bulkFill <= op_q == fps_pkg::FPS_IDLE && bulkCmd;
    end
  end
  // Status and read data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData <= `FPS_ZERO;
    end else if (busy || op_q == fps_pkg::FPS_ERR) begin
      rdData <= `FPS_ZERO;
      rdData[`FPS_BIT_POLL] <= ~polData_q[`FPS_BIT_POLL];
      rdData[`FPS_BIT_TOG] <= toggle_q ^ (rdStb && selAny && busy);
      rdData[`FPS_BIT_ERR] <= errFlag_q;
      rdData[`FPS_BIT_TMO] <= tmoFlag_q;
    end else if (|(sectorSelects & invalidSectors) ||
                 (op_q == fps_pkg::FPS_SUSP &&
                  |(sectorSelects & eraseSectors))) begin
      rdData <= ~arrayData;
    end else begin
      rdData <= arrayData;
    end
  end
  // Read-only protection view and ready/busy
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sectorWriteProtectStatus <= `FPS_ZERO;
      readyBusyOutput <= 1'b1;
    end else begin
      sectorWriteProtectStatus <= sectorProtect[7:0];
      readyBusyOutput <= !busy;
    end
  end
endmodule // fps_sequencer
`default_nettype wire

// ---- inc/fps_defs.svh ----
/*
 Timing counts, command codes and status bit positions for the
 flash program/erase sequencer. Assumes a 100 MHz system clock.
*/
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH
`define FPS_CLK_MHZ 100
`define FPS_TMO_US 100
`define FPS_TMO_PCT 20
`define FPS_TMO_CYC (`FPS_TMO_US * `FPS_CLK_MHZ)
`define FPS_TMO_MAX_CYC ((`FPS_TMO_CYC * (100 + `FPS_TMO_PCT)) / 100)
`define FPS_SUSP_NS 100
`define FPS_SUSP_CYC ((`FPS_SUSP_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_PROT_US 100
`define FPS_PROT_CYC (`FPS_PROT_US * `FPS_CLK_MHZ)
`define FPS_OP_CYC 64
`define FPS_ERASE_TRIES 4
`define FPS_CMD_AA 8'haa
`define FPS_CMD_55 8'h55
`define FPS_CMD_PROG 8'ha0
`define FPS_CMD_ERSU 8'h80
`define FPS_CMD_SERA 8'h30
`define FPS_CMD_BULK 8'h10
`define FPS_CMD_BYP 8'h20
`define FPS_CMD_BYPX 8'h90
`define FPS_CMD_BYPX2 8'h00
`define FPS_CMD_SUSP 8'hb0
`define FPS_CMD_RST 8'hf0
`define FPS_ADR_555 12'h555
`define FPS_ADR_AAA 12'haaa
`define FPS_BIT_POLL 7
`define FPS_BIT_TOG 6
`define FPS_BIT_ERR 5
`define FPS_BIT_TMO 3
`define FPS_ERASED 8'hff
`define FPS_ZERO 8'h00
`endif

// ---- inc/fps_pkg.sv ----
/*
 Types for the flash program/erase sequencer.
 Assumes fps_defs.svh holds all numeric constants.
*/
package fps_pkg;
  typedef enum logic [7:0] {
    FPS_IDLE = 8'h01,
    FPS_PROG = 8'h02,
    FPS_TMO = 8'h04,
    FPS_ERASE = 8'h08,
    FPS_SUSP = 8'h10,
    FPS_BULK = 8'h20,
    FPS_ERR = 8'h40,
    FPS_PROT = 8'h80
  } fps_op_e;
  typedef logic [7:0] fps_byte_t;
endpackage

// ---- rtl/fps_timer.sv ----
/*
 Down counter that pulses done when a loaded count runs out.
 Assumes a single system clock and async active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.svh"
module fps_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [14:0] count,
  input wire logic run,
  // Status
  output logic done
);
  logic [14:0] cnt_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 15'h0000;
    end else if (load) begin
      cnt_q <= count;
    end else if (run && cnt_q != 15'h0000) begin
      cnt_q <= cnt_q - 15'h0001;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= run && !load && cnt_q == 15'h0001;
    end
  end
endmodule // fps_timer
`default_nettype wire

// ---- rtl/fps_cmd_decode.sv ----
/*
 Unlock-prefix tracker: counts matching AA/555, 55/AAA cycles.
 Assumes one write pulse per bus write cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.svh"
module fps_cmd_decode (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Write cycle
  input wire logic wrStb,
  input wire logic [11:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic clear,
  // Prefix state
  output logic [2:0] stage
);
  // stage: 0 none, 1 AA, 2 AA55, 3 AA55-80, 4 +AA, 5 +55
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage <= 3'd0;
    end else if (clear) begin
      stage <= 3'd0;
    end else if (wrStb) begin
      if ((stage == 3'd0 || stage == 3'd3) && wrData == `FPS_CMD_AA &&
          wrAddr == `FPS_ADR_555) begin
        stage <= stage + 3'd1;
      end else if ((stage == 3'd1 || stage == 3'd4) &&
                   wrData == `FPS_CMD_55 && wrAddr == `FPS_ADR_AAA) begin
        stage <= stage + 3'd1;
      end else if (stage == 3'd2 && wrData == `FPS_CMD_ERSU &&
                   wrAddr == `FPS_ADR_555) begin
        stage <= 3'd3;
      end else begin
        stage <= 3'd0;
      end
    end
  end
endmodule // fps_cmd_decode
`default_nettype wire

// ---- tb/fps_array_model.sv ----
/*
 Byte array model standing behind the flash sequencer.
 Assumes sector n covers addresses n*100h to n*100h+ffh.
*/
`timescale 1ns/1ps
`default_nettype none
module fps_array_model (
  // Clock
  input wire logic sys_clk,
  // Sequencer side
  input wire logic [11:0] busAddr,
  input wire logic progReq,
  input wire logic [7:0] progData,
  input wire logic [11:0] eraseSectors,
  input wire logic eraseReq,
  input wire logic bulkReq,
  input wire logic bulkFill,
  output logic [7:0] arrayData,
  output logic opFail,
  // Fault injection
  input wire logic failMode
);
  logic [7:0] mem [4096];
  logic eraseQ = 1'b0;
  logic bulkQ = 1'b0;
  initial foreach (mem[i]) mem[i] = 8'hff;
  assign arrayData = mem[busAddr];
  assign opFail = failMode;
  always @(posedge sys_clk) begin
    eraseQ <= eraseReq;
    bulkQ <= bulkReq;
    if (progReq) mem[busAddr] <= progData;
    if (eraseReq && !eraseQ)
      foreach (mem[i]) if (eraseSectors[i>>8]) mem[i] <= 8'hff;
    if (bulkFill) foreach (mem[i]) mem[i] <= 8'h00;
    else if (bulkQ && !bulkReq && !failMode)
      foreach (mem[i]) mem[i] <= 8'hff;
  end
endmodule // fps_array_model
`default_nettype wire

// ---- tb/fps_sequencer_props.sv ----
/*
 Port checker for the flash sequencer.
 Assumes binding to fps_sequencer, one clock, reset active high.
*/
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus
  input wire logic rdStb,
  input wire logic [7:0] wrData,
  input wire logic [11:0] sectorSelects,
  input wire logic [7:0] arrayData,
  input wire logic [7:0] rdData,
  // Protection
  input wire logic [11:0] sectorProtect,
  input wire logic [7:0] sectorWriteProtectStatus,
  // Array requests
  input wire logic progReq,
  input wire logic [7:0] progData,
  input wire logic [11:0] eraseSectors,
  input wire logic eraseReq,
  input wire logic bulkReq,
  input wire logic bulkFill,
  input wire logic readyBusyOutput
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  prot_mirror_a: assert property (
    !$past(rst) |-> sectorWriteProtectStatus == $past(sectorProtect[7:0]))
    else $error("protection status differs from straps");
  prog_pulse_a: assert property (progReq |=> !progReq)
    else $error("program request longer than one cycle");
  prog_data_a: assert property (
    progReq |-> progData == ($past(arrayData) & $past(wrData)))
    else $error("program data sets bits");
  erase_busy_a: assert property (
    eraseReq |-> !readyBusyOutput && eraseSectors != 12'h000)
    else $error("erase while ready or with no sector");
  bulk_busy_a: assert property (
    bulkReq |-> !readyBusyOutput && !eraseReq && !progReq)
    else $error("bulk erase overlaps other work");
  fill_pulse_a: assert property (bulkFill |=> !bulkFill)
    else $error("fill pulse too long");
  tog_flip_a: assert property (
    rdStb && |sectorSelects && !readyBusyOutput
    ##2 rdStb && |sectorSelects && !readyBusyOutput
    |=> rdData[6] != $past(rdData[6], 2))
    else $error("toggle bit did not invert");
  poll_erase_a: assert property (
    rdStb && |sectorSelects && eraseReq |=> !rdData[7])
    else $error("polling bit high during erase");
  tmo_done_a: assert property (
    rdStb && |sectorSelects && eraseReq |=> rdData[3])
    else $error("time-out bit low during erase");
  cover property ($rose(eraseReq));
  cover property (bulkFill);
  cover property (progReq);
endmodule // fps_sequencer_props
`default_nettype wire

// ---- tb/tb.sv ----
/*
 Self-checking bench for the flash sequencer with array model.
 Assumes 100 MHz clock and fps_defs.svh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.svh"
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin \
  numErrors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  logic sys_clk = 1'b0;
  logic rst, wrStb, rdStb, opFail, failMode;
  logic [11:0] busAddr, sectorSelects, sectorProtect, eraseSectors;
  logic [7:0] wrData, arrayData, rdData, protStat, progData, rv, d;
  logic progReq, eraseReq, bulkReq, bulkFill, readyBusyOutput, t;
  logic [11:0] a, invSec;
  logic [11:0] progA [6];
  logic [7:0] sh [4096];
  integer seed;
  int numErrors = 0;
  int samplesChecked = 0;
  int cyc;
  always #5 sys_clk = ~sys_clk;
  fps_sequencer fps_sequencer_inst (.sys_clk(sys_clk), .rst(rst),
    .wrStb(wrStb), .rdStb(rdStb), .busAddr(busAddr), .wrData(wrData),
    .sectorSelects(sectorSelects), .arrayData(arrayData),
    .rdData(rdData), .sectorProtect(sectorProtect),
    .sectorWriteProtectStatus(protStat), .progReq(progReq),
    .progData(progData), .eraseSectors(eraseSectors),
    .eraseReq(eraseReq), .bulkReq(bulkReq), .bulkFill(bulkFill),
    .invalidSectors(invSec), .opFail(opFail),
    .readyBusyOutput(readyBusyOutput));
  fps_array_model fps_array_model_inst (.sys_clk(sys_clk),
    .busAddr(busAddr), .progReq(progReq), .progData(progData),
    .eraseSectors(eraseSectors), .eraseReq(eraseReq),
    .bulkReq(bulkReq), .bulkFill(bulkFill), .arrayData(arrayData),
    .opFail(opFail), .failMode(failMode));
  function automatic logic [11:0] sel(input logic [11:0] x);
    return 12'h1 << x[11:8];
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] v, input logic [11:0] x);
    @(posedge sys_clk);
    busAddr <= x;
    wrData <= v;
    sectorSelects <= sel(x);
    wrStb <= 1'b1;
    @(posedge sys_clk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] x);
    @(posedge sys_clk);
    busAddr <= x;
    sectorSelects <= sel(x);
    rdStb <= 1'b1;
    @(posedge sys_clk);
    rdStb <= 1'b0;
    @(negedge sys_clk);
    rv = rdData;
  endtask
  task automatic waitRdy(input int lim);
    cyc = 0;
    repeat (2) @(negedge sys_clk);
    while (readyBusyOutput !== 1'b1 && cyc < lim) begin
      @(negedge sys_clk);
      cyc++;
    end
    `CHK("ready", 1'b1, readyBusyOutput)
  endtask
  task automatic unl(input logic [7:0] c);
    wr(8'haa, 12'h555);
    wr(8'h55, 12'haaa);
    wr(c, 12'h555);
  endtask
  task automatic erase(input logic [7:0] c, input logic [11:0] x);
    unl(8'h80);
    wr(8'haa, 12'h555);
    wr(8'h55, 12'haaa);
    wr(c, x);
  endtask
  task automatic eraseSh(input int s);
    foreach (sh[i]) if (i[11:8] == s) sh[i] = 8'hff;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    numErrors++;
    $display("[ERR] watchdog expired");
    conclude();
  end
  initial begin
    seed = 32'h7c626ea1;
    rst = 1'b1;
    wrStb = 1'b0;
    rdStb = 1'b0;
    busAddr = 12'h000;
    wrData = 8'h00;
    sectorSelects = 12'h000;
    sectorProtect = 12'h880;
    failMode = 1'b0;
    foreach (sh[i]) sh[i] = 8'hff;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK("rdy0", 1'b1, readyBusyOutput)
    `CHK("prot", 8'h80, protStat)
    for (int k = 0; k < 6; k++) begin
      a = 12'($random(seed));
      a[11:8] = 4'(k);
      d = 8'($random(seed));
      progA[k] = a;
      unl(8'ha0);
      wr(d, a);
      waitRdy(300);
      rd(a);
      sh[a] = sh[a] & d;
      `CHK("prog", sh[a], rv)
    end
    unl(8'ha0);
    wr(8'h00, 12'h7a5);
    repeat (80) @(posedge sys_clk);
    rd(12'h7a5);
    `CHK("protprog", 8'hff, rv)
    unl(8'h20);
    wr(8'h80, 12'h555);
    d = 8'($random(seed));
    wr(8'ha0, 12'h000);
    wr(d, 12'h1c3);
    waitRdy(300);
    rd(12'h1c3);
    sh[12'h1c3] = sh[12'h1c3] & d;
    `CHK("byp", sh[12'h1c3], rv)
    wr(8'h90, 12'h000);
    wr(8'h00, 12'h000);
    wr(8'ha0, 12'h000);
    wr(8'h00, 12'h1c4);
    repeat (80) @(posedge sys_clk);
    rd(12'h1c4);
    `CHK("bypx", sh[12'h1c4], rv)
    erase(8'h30, 12'h200);
    rd(12'h200);
    `CHK("tmo0", 1'b0, rv[3])
    `CHK("poll0", 1'b0, rv[7])
    t = rv[6];
    rd(12'h200);
    `CHK("tog", ~t, rv[6])
    wr(8'h30, 12'h300);
    waitRdy(13000);
    `CHK("win", 1'b1, cyc >= `FPS_TMO_CYC - 8)
    `CHK("winmax", 1'b1, cyc <= `FPS_TMO_MAX_CYC + 200)
    eraseSh(2);
    eraseSh(3);
    rd(progA[2]);
    `CHK("ers2", 8'hff, rv)
    rd(progA[3]);
    `CHK("ers3", 8'hff, rv)
    erase(8'h30, 12'h400);
    wr(8'ha0, 12'h555);
    waitRdy(40);
    rd(progA[4]);
    `CHK("abort", sh[progA[4]], rv)
    erase(8'h30, 12'h100);
    cyc = 0;
    while (eraseReq !== 1'b1 && cyc < 13000) begin
      @(negedge sys_clk);
      cyc++;
    end
    rd(12'h100);
    wr(8'hb0, 12'h100);
    repeat (20) @(posedge sys_clk);
    rd(12'h100);
    t = rv[6];
    rd(12'h100);
    `CHK("susptog", t, rv[6])
    rd(progA[0]);
    `CHK("suspok", sh[progA[0]], rv)
    rd(12'h1c3);
    `CHK("inval", 1'b1, rv !== 8'hff)
    unl(8'ha0);
    wr(8'h00, progA[0]);
    repeat (80) @(posedge sys_clk);
    rd(progA[0]);
    `CHK("suspprog", sh[progA[0]], rv)
    wr(8'h30, 12'h100);
    waitRdy(13000);
    eraseSh(1);
    rd(12'h1c3);
    `CHK("resume", 8'hff, rv)
    `CHK("invs", 12'h000, invSec)
    erase(8'h11, 12'h555);
    waitRdy(8);
    `CHK("bulkab", 1'b0, bulkReq)
    @(posedge sys_clk);
    failMode <= 1'b1;
    unl(8'ha0);
    wr(8'h0f, 12'h0f0);
    sh[12'h0f0] = sh[12'h0f0] & 8'h0f;
    repeat (100) @(posedge sys_clk);
    rd(12'h0f0);
    `CHK("err", 1'b1, rv[5])
    failMode <= 1'b0;
    rd(12'h0f0);
    `CHK("errhold", 1'b1, rv[5])
    wr(8'hf0, 12'h000);
    waitRdy(3000);
    rd(12'h0f0);
    `CHK("errclr", sh[12'h0f0], rv)
    erase(8'h10, 12'h555);
    wr(8'hf0, 12'h000);
    @(negedge sys_clk);
    `CHK("bulkbusy", 1'b0, readyBusyOutput)
    waitRdy(5000);
    rd(progA[5]);
    `CHK("bulk", 8'hff, rv)
    conclude();
  end
endmodule // tb
bind fps_sequencer fps_sequencer_props fps_sequencer_props_inst (
  .sys_clk(sys_clk), .rst(rst), .rdStb(rdStb), .wrData(wrData),
  .sectorSelects(sectorSelects), .arrayData(arrayData),
  .rdData(rdData), .sectorProtect(sectorProtect),
  .sectorWriteProtectStatus(sectorWriteProtectStatus),
  .progReq(progReq), .progData(progData), .eraseSectors(eraseSectors),
  .eraseReq(eraseReq), .bulkReq(bulkReq), .bulkFill(bulkFill),
  .readyBusyOutput(readyBusyOutput));
`default_nettype wire
